/* sw_map.svh */
`ifndef SW_MAP_SVH
`define SW_MAP_SVH

// register indices; byte address is four times the index
`define SW_IDX_CTL 16'hFF7C
`define SW_IDX_HUN 16'hFF7D
`define SW_IDX_TEN 16'hFF7E
`define SW_IDX_IEN 16'hFFE7
`define SW_IDX_IFL 16'hFFF7

// field positions
`define SW_RUN_BIT 0
`define SW_CLR_BIT 1
`define SW_TEN_BIT 0
`define SW_SEC_BIT 1

// reset values and bcd digit maximum
`define SW_RST_DIG 4'h0
`define SW_RST_IRQ 2'h0
`define SW_BCD_MAX 4'h9

// timing: core clock and base tick rate, in Hz
`define SW_CLK_HZ 50000000
`define SW_BASE_HZ 256
// longest whole count of clocks per base period
`define SW_TICK_CYC (`SW_CLK_HZ / `SW_BASE_HZ)
// phase added per base tick; wraps at 256
`define SW_STEP_ADD 8'h64
// base ticks in one second of the tenths digit
`define SW_SEC_TICKS 9'h100
// decade spans of the hundredths digit, in base ticks
`define SW_DEC_SHORT 5'h19
`define SW_DEC_LONG  5'h1A
// longest pause software may hold the counter, in us
`define SW_PAUSE_US 976

`endif

/* sw_pkg.sv */
package sw_pkg;
  // one bcd digit
  typedef logic [3:0] bcd_t;
  // one bit per stopwatch event: tenth tick, second tick
  typedef logic [1:0] irq_vec_t;
  // decoded register target of a bus request
  typedef enum {
    REG_CTL,
    REG_HUN,
    REG_TEN,
    REG_IEN,
    REG_IFL,
    REG_NONE
  } reg_sel_e;
endpackage

/* sw_pace_if.sv */
`timescale 1ns/1ps
// pacing link between the digit logic and the step generator
interface sw_pace_if;
  logic run;       // counting enabled
  logic clear;     // one-cycle zeroing strobe
  logic base_tick; // one-cycle pulse at 256 Hz
  logic step;      // one-cycle hundredths advance
  modport main  (output run, output clear, input base_tick, input step);
  modport pacer (input run, input clear, output base_tick, output step);
endinterface

/* sw_pacer.sv */
`timescale 1ns/1ps
`include "sw_map.svh"

// step generator: 256 Hz base tick and 100-per-second phase
module sw_pacer #(
  parameter int TICK_DIV = `SW_TICK_CYC // clocks per base tick
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pacing link
  sw_pace_if.pacer pif
);

  logic [17:0] div_q;  // base period divider
  logic        tick_q; // base tick pulse
  logic [7:0]  acc_q;  // phase accumulator
  logic        step_q; // hundredths step pulse
  logic [8:0]  sum;    // accumulator plus carry
  logic [1:0]  gap_q;  // base ticks since last step

  // divider runs free, like a prescaler tap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= 18'h0;
      tick_q <= 1'b0;
    end else if (div_q == 18'(TICK_DIV - 1)) begin
      div_q  <= 18'h0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 18'h1;
      tick_q <= 1'b0;
    end
  end

  // carry of the phase gives 2 or 3 ticks per step
  assign sum = {1'b0, acc_q} + {1'b0, `SW_STEP_ADD}; // see R2

  // accumulator moves only while running or on a clear; held otherwise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_q  <= 8'h0;
      step_q <= 1'b0;
    end else if (pif.clear) begin
      acc_q  <= 8'h0; // realign phase to the zeroed digits
      step_q <= 1'b0;
    end else if (pif.run && tick_q) begin
      acc_q  <= sum[7:0]; // see R2
      step_q <= sum[8];
    end else begin
      step_q <= 1'b0;
    end
  end

  assign pif.base_tick = tick_q;
  assign pif.step      = step_q;

  // helper: counts running base ticks between steps
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 2'h0;
    end else if (pif.clear || (pif.run && tick_q && sum[8])) begin
      gap_q <= 2'h0;
    end else if (pif.run && tick_q) begin
      gap_q <= gap_q + 2'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_step_gap: assert property ( // see R2
    (pif.run && tick_q && sum[8] && !pif.clear)
      |-> (gap_q == 2'h1 || gap_q == 2'h2))
    else $error("step spacing not 2 or 3 base ticks");

endmodule

/* bcd_stopwatch_timer.sv */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "sw_map.svh"

// Contract
// R1: two cascaded bcd digits, hundredths and tenths
// R2: hundredths steps every two or three ticks
// R3: hundredths decade spans 25 or 26 ticks
// R4: tenths decade spans exactly 256 ticks
// R5: each digit wrap sets its flag
// R6: flags set always; enable gates request
// R7: enable bits readable, reset to zero
// R8: digits readable as nibbles, writes ignored
// R9: reset zeroes digits and run bit
// R10: writing one to clear zeroes digits
// R11: clear keeps run state as it was; the code loads run from the run bit of the same write
// R12: run bit read/write, starts and stops
// R13: stopped digits hold, resume on run
// R14: software pause stays below 976 us
// R15: flags read one, write one clears
// R16: tenths carry on the same step
module bcd_stopwatch_timer #(
  parameter int TICK_DIV = `SW_TICK_CYC // clocks per 256 Hz tick
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt request, level
  output logic             irq
);

  // pacing link to the step generator
  sw_pace_if pif ();

  // bus state
  sw_pkg::reg_sel_e sel;       // decoded target
  logic             setup;     // apb setup cycle
  logic             access;    // completing access cycle
  logic             wr;        // write takes effect
  logic [31:0]      rd_d;      // read data for the target
  logic [31:0]      prdata_q;  // registered read data
  logic             pready_q;  // registered ready
  logic             pslverr_q; // registered error

  // control and status
  logic             run_q;     // counting enabled
  logic             clr;       // clear strobe, this cycle
  sw_pkg::bcd_t     hund_q;    // hundredths digit
  sw_pkg::bcd_t     tenth_q;   // tenths digit
  sw_pkg::irq_vec_t ien_q;     // interrupt enables
  sw_pkg::irq_vec_t flag_q;    // sticky event flags
  sw_pkg::irq_vec_t ev;        // wrap events, this cycle
  logic             step_ok;   // step not swallowed by clear
  logic             irq_q;     // registered request
  logic             irq_d;     // request before its register

  // step generator
  sw_pacer #(
    .TICK_DIV (TICK_DIV)
  ) u_pacer (
    .clock (clock),
    .rst_n (rst_n),
    .pif   (pif.pacer)
  );

  // address decode; misaligned or unlisted gives error
  always_comb begin
    sel = sw_pkg::REG_NONE;
    if (paddr[1:0] == 2'h0) begin
      case (paddr[17:2])
        `SW_IDX_CTL: sel = sw_pkg::REG_CTL;
        `SW_IDX_HUN: sel = sw_pkg::REG_HUN;
        `SW_IDX_TEN: sel = sw_pkg::REG_TEN;
        `SW_IDX_IEN: sel = sw_pkg::REG_IEN;
        `SW_IDX_IFL: sel = sw_pkg::REG_IFL;
        default:     sel = sw_pkg::REG_NONE;
      endcase
    end
  end

  // phase strobes; ready is high through every access
  assign setup  = psel && !penable;
  assign access = psel && penable && pready_q;
  assign wr     = access && pwrite && !pslverr_q;

  // read mux; unused upper bits read zero
  always_comb begin
    rd_d = 32'h0;
    case (sel)
      sw_pkg::REG_CTL: begin
        // clear strobe always reads zero
        rd_d[`SW_RUN_BIT] = run_q; // see R12 R10
      end
      sw_pkg::REG_HUN: rd_d[3:0] = hund_q;  // see R8
      sw_pkg::REG_TEN: rd_d[3:0] = tenth_q; // see R8
      sw_pkg::REG_IEN: rd_d[1:0] = ien_q;   // see R7
      sw_pkg::REG_IFL: rd_d[1:0] = flag_q;  // see R15
      default:         rd_d = 32'h0;
    endcase
  end

  // bus answer, prepared in the setup cycle
  // zero wait states: pready rises for the access cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= (sel == sw_pkg::REG_NONE);
        prdata_q  <= pwrite ? 32'h0 : rd_d;
      end else if (access) begin
        pslverr_q <= 1'b0;
        prdata_q  <= 32'h0;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // clear acts on the write edge only; zero writes do nothing
  assign clr = wr && (sel == sw_pkg::REG_CTL)
               && pwdata[`SW_CLR_BIT]; // see R10

  // run bit; a clear in the same write leaves it as written
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0; // see R9
    end else if (wr && sel == sw_pkg::REG_CTL) begin
      run_q <= pwdata[`SW_RUN_BIT]; // see R12 R11
    end
  end

  // interrupt enables
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ien_q <= `SW_RST_IRQ; // see R7
    end else if (wr && sel == sw_pkg::REG_IEN) begin
      ien_q <= pwdata[1:0]; // see R7
    end
  end

  // link to the pacer
  assign pif.run   = run_q;
  assign pif.clear = clr;

  // pacer only steps while running; clear swallows a step
  assign step_ok = pif.step && !clr; // see R13

  // wraps: tenths carry on the very step the hundredths wraps
  assign ev[`SW_TEN_BIT] = step_ok
                           && (hund_q == `SW_BCD_MAX); // see R5
  assign ev[`SW_SEC_BIT] = ev[`SW_TEN_BIT]
                           && (tenth_q == `SW_BCD_MAX); // see R5

  // hundredths digit
  // a write to the digit registers never reaches here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hund_q <= `SW_RST_DIG; // see R9
    end else if (clr) begin
      hund_q <= `SW_RST_DIG; // see R10 R11
    end else if (ev[`SW_TEN_BIT]) begin
      hund_q <= `SW_RST_DIG; // see R1 R3
    end else if (step_ok) begin
      hund_q <= hund_q + 4'h1; // see R1 R2
    end
  end

  // tenths digit, stepped by the hundredths wrap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tenth_q <= `SW_RST_DIG; // see R9
    end else if (clr) begin
      tenth_q <= `SW_RST_DIG; // see R10
    end else if (ev[`SW_SEC_BIT]) begin
      tenth_q <= `SW_RST_DIG; // see R1 R4
    end else if (ev[`SW_TEN_BIT]) begin
      tenth_q <= tenth_q + 4'h1; // see R16 R3
    end
  end

  // sticky flags, one per event
  // set wins over a write-one clear in the same cycle
  for (genvar i = 0; i < 2; i++) begin : g_flag
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        flag_q[i] <= 1'b0; // see R15
      end else if (ev[i]) begin
        flag_q[i] <= 1'b1; // see R5 R6
      end else if (wr && sel == sw_pkg::REG_IFL && pwdata[i]) begin
        flag_q[i] <= 1'b0; // see R15
      end
    end
  end

  // or of the enabled flags, registered below
  assign irq_d = |(flag_q & ien_q); // see R6

  // one level request, high while an enabled flag is set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d; // see R6
    end
  end

  assign irq = irq_q;

  // helper: running base ticks since the last second wrap
  logic [8:0] sec_cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt_q <= 9'h0;
    end else if (clr || ev[`SW_SEC_BIT]) begin
      sec_cnt_q <= 9'h0;
    end else if (run_q && pif.base_tick) begin
      sec_cnt_q <= sec_cnt_q + 9'h1;
    end
  end

  // helper: running base ticks since the last tenth wrap
  logic [4:0] dec_cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dec_cnt_q <= 5'h0;
    end else if (clr || ev[`SW_TEN_BIT]) begin
      dec_cnt_q <= 5'h0;
    end else if (run_q && pif.base_tick) begin
      dec_cnt_q <= dec_cnt_q + 5'h1;
    end
  end

  // helper: a reset or clear has happened since the last tenth wrap
  logic fresh_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fresh_q <= 1'b1;
    end else if (clr) begin
      fresh_q <= 1'b1;
    end else if (ev[`SW_TEN_BIT]) begin
      fresh_q <= 1'b0;
    end
  end

  // helper: a clear landed while running; waits for the first step
  logic clr_run_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clr_run_q <= 1'b0;
    end else if (clr && run_q) begin
      clr_run_q <= 1'b1;
    end else if (step_ok) begin
      clr_run_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_bcd_range: assert property ( // see R1
    hund_q <= `SW_BCD_MAX && tenth_q <= `SW_BCD_MAX)
    else $error("digit left bcd range");

  a_decade_span: assert property ( // see R3
    (ev[`SW_TEN_BIT] && !fresh_q)
      |-> (dec_cnt_q == `SW_DEC_SHORT || dec_cnt_q == `SW_DEC_LONG))
    else $error("hundredths decade not 25 or 26 ticks");

  a_sec_exact: assert property ( // see R4
    ev[`SW_SEC_BIT] |-> sec_cnt_q == `SW_SEC_TICKS)
    else $error("tenths decade not 256 ticks");

  a_hund_wrap: assert property ( // see R5 R16
    (step_ok && hund_q == `SW_BCD_MAX && tenth_q != `SW_BCD_MAX)
      |=> (hund_q == 4'h0 && tenth_q == $past(tenth_q) + 4'h1
           && flag_q[`SW_TEN_BIT]))
    else $error("hundredths wrap did not carry or flag");

  a_flag_masked: assert property ( // see R6
    (ev[`SW_SEC_BIT] && !ien_q[`SW_SEC_BIT])
      |=> flag_q[`SW_SEC_BIT] && flag_q[`SW_TEN_BIT])
    else $error("masked event did not set its flag");

  a_irq_level: assert property ( // see R6 R7
    ##1 irq == $past(irq_d))
    else $error("request does not follow enabled flags");

  a_digit_ro: assert property ( // see R8
    (wr && (sel == sw_pkg::REG_HUN || sel == sw_pkg::REG_TEN)
     && !step_ok) |=> $stable(hund_q) && $stable(tenth_q))
    else $error("digit write changed a digit");

  a_clear_zero: assert property ( // see R10 R11
    clr |=> hund_q == 4'h0 && tenth_q == 4'h0
            && run_q == $past(pwdata[`SW_RUN_BIT]))
    else $error("clear did not zero digits");

  a_ctl_read: assert property ( // see R10 R12
    (access && !pwrite && sel == sw_pkg::REG_CTL)
      |-> prdata[`SW_CLR_BIT] == 1'b0
          && prdata[`SW_RUN_BIT] == run_q)
    else $error("control read back wrong");

  a_stop_hold: assert property ( // see R13
    (!run_q && !clr) [*2] |=> $stable(hund_q) && $stable(tenth_q))
    else $error("digits moved while stopped");

  a_flag_w1c: assert property ( // see R15
    (wr && sel == sw_pkg::REG_IFL && pwdata[`SW_TEN_BIT]
     && !ev[`SW_TEN_BIT]) |=> !flag_q[`SW_TEN_BIT])
    else $error("write one did not clear flag");

  a_sec_w1c: assert property ( // see R15
    (wr && sel == sw_pkg::REG_IFL && pwdata[`SW_SEC_BIT]
     && !ev[`SW_SEC_BIT]) |=> !flag_q[`SW_SEC_BIT])
    else $error("write one did not clear second flag");

  a_clear_resume: assert property ( // see R11
    (clr_run_q && step_ok) |=> hund_q == 4'h1 && tenth_q == 4'h0)
    else $error("count did not resume from zero");

  a_en_hold: assert property ( // see R7
    !(wr && sel == sw_pkg::REG_IEN) |=> $stable(ien_q))
    else $error("enables moved without a write");

  a_run_hold: assert property ( // see R12
    !(wr && sel == sw_pkg::REG_CTL) |=> $stable(run_q))
    else $error("run bit moved without a write");

  c_sec_wrap: cover property (ev[`SW_SEC_BIT]);
  c_clr_run: cover property (clr_run_q && step_ok);
  c_irq_on: cover property (irq && flag_q == 2'h3);
  c_set_clr: cover property (
    ev[`SW_TEN_BIT] && wr && sel == sw_pkg::REG_IFL);

endmodule

/* tb_top.sv */
`timescale 1ns/1ps
`include "sw_map.svh"

module tb_top;
  // short base period keeps one second at 1024 clocks
  localparam int TDIV = 4;
  // byte addresses are four times the register index
  localparam logic [17:0] A_CTL = {`SW_IDX_CTL, 2'b00};
  localparam logic [17:0] A_HUN = {`SW_IDX_HUN, 2'b00};
  localparam logic [17:0] A_TEN = {`SW_IDX_TEN, 2'b00};
  localparam logic [17:0] A_IEN = {`SW_IDX_IEN, 2'b00};
  localparam logic [17:0] A_IFL = {`SW_IDX_IFL, 2'b00};

  logic        clock;        // core clock
  logic        rst_n;        // async reset
  logic        psel;         // apb select
  logic        penable;      // apb access phase
  logic        pwrite;       // apb direction
  logic [17:0] paddr;        // apb address
  logic [31:0] pwdata;       // apb write data
  logic [31:0] prdata;       // apb read data
  logic        pready;       // apb ready
  logic        pslverr;      // apb error
  logic        irq;          // level interrupt
  int          miscompares;  // mismatches seen
  int          n_compared;   // comparisons made

  bcd_stopwatch_timer #(.TICK_DIV(TDIV)) i_bcd_stopwatch_timer (
    .clock   (clock),
    .rst_n   (rst_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq)
  );

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // compare one value, count and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; answer taken at the rising edge where pready
  // is seen high, then the request is released
  task automatic apb(input logic wr, input logic [17:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no local limit: a slave that never answers trips the watchdog
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // write a register, expect an okay response
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask

  // read a register and compare, expect an okay response
  task automatic rdc(input logic [17:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk({31'h0, e}, 32'h0);
    chk(r, exp);
  endtask

  // count settled edges until irq rises, bounded
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (irq !== 1'b1 && n < lim);
  endtask

  // reset values of every register and of irq
  task automatic t_reset;
    rdc(A_CTL, 32'h0);
    rdc(A_HUN, 32'h0);
    rdc(A_TEN, 32'h0);
    rdc(A_IEN, 32'h0);
    rdc(A_IFL, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  // access kinds, read-only digits and refused addresses
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    wr(A_IEN, 32'h3);
    rdc(A_IEN, 32'h3);
    wr(A_IEN, 32'h0);
    wr(A_CTL, 32'h1);
    rdc(A_CTL, 32'h1);
    wr(A_CTL, 32'h0);
    rdc(A_CTL, 32'h0);
    wr(A_CTL, 32'h2);
    rdc(A_CTL, 32'h0);
    wr(A_HUN, 32'h7);
    wr(A_TEN, 32'h5);
    rdc(A_HUN, 32'h0);
    rdc(A_TEN, 32'h0);
    // unmapped and misaligned places answer with an error
    apb(1'b0, 18'h00010, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'b0, A_CTL + 18'h1, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    // refused writes leave the enables alone
    apb(1'b1, 18'h00010, 32'h3, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, A_IEN + 18'h2, 32'h3, r, e);
    chk({31'h0, e}, 32'h1);
    rdc(A_IEN, 32'h0);
  endtask

  // first hundredths decade from a clear, carry into tenths, flags
  task automatic t_tenth;
    int n;
    wr(A_IFL, 32'h3);
    wr(A_IEN, 32'h1);
    wr(A_CTL, 32'h3);
    wait_irq(300, n);
    chk(32'(n >= 100 && n <= 110), 32'h1);
    wr(A_CTL, 32'h0);
    rdc(A_HUN, 32'h0);
    rdc(A_TEN, 32'h1);
    rdc(A_IFL, 32'h1);
    wr(A_IFL, 32'h0);
    rdc(A_IFL, 32'h1);
    wr(A_IFL, 32'h1);
    rdc(A_IFL, 32'h0);
    repeat (3) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
  endtask

  // stop holds, resume continues, clear while stopped stays zero
  task automatic t_hold;
    int n;
    repeat (200) @(posedge clock);
    rdc(A_HUN, 32'h0);
    rdc(A_TEN, 32'h1);
    wr(A_CTL, 32'h1);
    wait_irq(300, n);
    chk(32'(n >= 90 && n <= 112), 32'h1);
    wr(A_CTL, 32'h0);
    rdc(A_TEN, 32'h2);
    wr(A_IFL, 32'h1);
    wr(A_CTL, 32'h2);
    rdc(A_HUN, 32'h0);
    rdc(A_TEN, 32'h0);
    repeat (100) @(posedge clock);
    rdc(A_TEN, 32'h0);
  endtask

  // masked flags still set over a full second, request stays low
  task automatic t_masked;
    wr(A_IEN, 32'h0);
    wr(A_CTL, 32'h3);
    repeat (1100) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    wr(A_CTL, 32'h0);
    rdc(A_IFL, 32'h3);
  endtask

  // one full second from a clear that also starts the count
  task automatic t_second;
    int n;
    wr(A_IFL, 32'h3);
    wr(A_IEN, 32'h2);
    wr(A_CTL, 32'h3);
    wait_irq(1200, n);
    chk(32'(n >= 1018 && n <= 1032), 32'h1);
    wr(A_CTL, 32'h0);
    rdc(A_HUN, 32'h0);
    rdc(A_TEN, 32'h0);
    rdc(A_IFL, 32'h3);
    wr(A_IFL, 32'h3);
  endtask

  // verdict, in one place only
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog: whole run is a few thousand clocks
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end

  // main sequence
  initial begin
    miscompares = 0;
    n_compared  = 0;
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 18'h0;
    pwdata  = 32'h0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_tenth();
    t_hold();
    t_masked();
    t_second();
    end_of_test();
  end
endmodule
